// [test/psta_flash_model.sv]
// Purpose: Combinational program array standing beyond the block
// Assumes: Read data valid in the cycle of the read strobe
// Notes:   Released bus shows the inverse of its last value
`timescale 1ns/1ps
module psta_flash_model (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire psta_pkg::psta_mem_t mem_cmd,
    output logic [23:0]              mem_rdata
);
    import psta_pkg::*;
    logic [23:0] last_q;
    // Word content depends on every address bit, page included
    function automatic logic [23:0] word_at(input logic [23:0] a);
        return {a[7:0] ^ a[23:16] ^ 8'h3C,
                a[15:0] ^ {a[23:16], a[23:16]} ^ 16'hA5C3};
    endfunction
    assign mem_rdata = mem_cmd.read ? word_at(mem_cmd.addr) : ~last_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            last_q <= 24'h00_0000;
        else
            last_q <= mem_rdata;
    end
endmodule // psta_flash_model

// [test/psta_top_props.sv]
// Purpose: Port assertions for the table access block
// Assumes: Bound onto psta_top, one clock domain
// Notes:   Busy lengths measured by helper counters
`timescale 1ns/1ps
module psta_top_props #(
    parameter int ERASE_LEN = 20,
    parameter int PROG_LEN  = 5
) (
    input wire logic                pclk,
    input wire logic                presetn,
    input wire psta_pkg::psta_req_t tbl_req,
    input wire logic                tbl_ack,
    input wire logic [15:0]         tbl_rdata,
    input wire logic                win_ack,
    input wire logic [15:0]         win_rdata,
    input wire logic [22:0]         pc_word_index,
    input wire logic [23:0]         pc_addr,
    input wire psta_pkg::psta_mem_t mem_cmd,
    input wire logic [23:0]         mem_rdata,
    input wire logic                flash_erase_busy,
    input wire logic                flash_prog_busy,
    input wire logic [23:0]         flash_addr,
    input wire logic [23:0]         latch_lo_q,
    input wire logic                cpu_stall,
    input wire logic                idle_req
);
    import psta_pkg::*;
    logic [31:0] ecnt_q, ecnt_d, pcnt_q, pcnt_d;
    logic        rd_lo, rd_hi, bm, wr_lo;
    always_comb begin
        ecnt_d = flash_erase_busy ? ecnt_q + 32'h1 : 32'h0;
        pcnt_d = flash_prog_busy ? pcnt_q + 32'h1 : 32'h0;
        bm = tbl_req.byte_mode;
        rd_lo = tbl_ack && tbl_req.op == PSTA_RD_LOW;
        rd_hi = tbl_ack && tbl_req.op == PSTA_RD_HIGH;
        wr_lo = tbl_ack && tbl_req.op == PSTA_WR_LOW && !bm;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ecnt_q <= 32'h0;
            pcnt_q <= 32'h0;
        end else begin
            ecnt_q <= ecnt_d;
            pcnt_q <= pcnt_d;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    pc_step_a:
        assert property (pc_addr == {pc_word_index, 1'b0})
        else $error("pc_addr is not twice the word index");
    addr_even_a:
        assert property (mem_cmd.read |-> !mem_cmd.addr[0] && !flash_addr[0])
        else $error("program address bit zero set");
    low_word_a:
        assert property (rd_lo && !bm |=> tbl_rdata == $past(mem_rdata[15:0]))
        else $error("low word read wrong");
    low_byte_a:
        assert property (rd_lo && bm |=> tbl_rdata[7:0] == ($past(tbl_req.ea[0])
            ? $past(mem_rdata[15:8]) : $past(mem_rdata[7:0])))
        else $error("low byte read wrong");
    high_word_a:
        assert property (rd_hi && !bm |=>
            tbl_rdata == {8'h00, $past(mem_rdata[23:16])})
        else $error("high word read wrong");
    phantom_zero_a:
        assert property (rd_hi && bm && tbl_req.ea[0] |=> tbl_rdata[7:0] == 8'h00)
        else $error("phantom byte not zero");
    window_low_a:
        assert property (win_ack |=> win_rdata == $past(mem_rdata[15:0]))
        else $error("window read wrong");
    stall_hold_a:
        assert property (flash_erase_busy || flash_prog_busy |->
            cpu_stall && !tbl_ack)
        else $error("core not stalled during flash operation");
    erase_len_a:
        assert property ($fell(flash_erase_busy) && !$past(idle_req) |->
            ecnt_q == ERASE_LEN)
        else $error("erase length wrong");
    prog_len_a:
        assert property ($fell(flash_prog_busy) |-> pcnt_q == PROG_LEN)
        else $error("program length wrong");
    latch_low_a:
        assert property (wr_lo && !tbl_req.ea[1] |=>
            latch_lo_q[15:0] == $past(tbl_req.wdata))
        else $error("low latch not written");
endmodule // psta_top_props

// [test/test_program_space_table_access.sv]
// Purpose: Self-checking bench for the table access block
// Assumes: APB master tasks, array model on the flash side
// Notes:   Short operation lengths keep the run brief
`timescale 1ns/1ps
module test_program_space_table_access;
    import psta_pkg::*;
    localparam int EL = 20;
    localparam int PL = 5;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, win_valid = 1'b0, idle_req = 1'b0;
    logic [7:0]  paddr = 8'h00, win_page = 8'h00, pg = 8'h00;
    logic [14:0] win_ea = 15'h0000;
    logic [22:0] pc_word_index = 23'h00_0000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    psta_req_t   tbl_req = '0;
    psta_mem_t   mem_cmd;
    logic        pready, pslverr, err_seen, tbl_ack, win_ack, cpu_stall;
    logic        flash_erase_busy, flash_prog_busy;
    logic [15:0] tbl_rdata, win_rdata;
    logic [23:0] pc_addr, mem_rdata, flash_addr, latch_lo_q, latch_hi_q;
    logic [5:0]  bmv = 6'b110110, eav = 6'b101011;
    int          num_errors = 0, tests_run = 0;
    always #10 pclk = ~pclk;
    psta_top #(.ERASE_LEN(EL), .PROG_LEN(PL)) i_psta_top (.*);
    psta_flash_model i_psta_flash_model (.*);
    // ***************************************************************
    // Tasks
    // ***************************************************************
    task automatic chk(input string what, input logic [31:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err_seen = pslverr;
        chk("apb answer", 32'h1, {31'h0, pready});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic tbl(input psta_op_t op, input logic bm,
                       input logic [15:0] ea, wd);
        int n;
        tbl_req <= '{1'b1, op, bm, ea, wd};
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (tbl_ack !== 1'b1 && n < 100);
        chk("table ack", 32'h1, {31'h0, tbl_ack});
        tbl_req.valid <= 1'b0;
        @(posedge pclk);
        rd = {16'h0000, tbl_rdata};
    endtask
    task automatic start(input logic [31:0] ctl, input int mode);
        if (mode != 2)
            apb(1'b1, PSTA_KEY_OFF, {24'h00_0000, KEY_FIRST});
        if (mode == 1)
            apb(1'b1, PSTA_ADRL_OFF, 32'h0000_1235);
        if (mode != 2)
            apb(1'b1, PSTA_KEY_OFF, {24'h00_0000, KEY_SECOND});
        apb(1'b1, PSTA_CTRL_OFF, ctl);
        @(posedge pclk);
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        while (cpu_stall !== 1'b0 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        chk("stall released", 32'h0, {31'h0, cpu_stall});
    endtask
    function automatic logic [23:0] pw(input logic [23:0] a);
        return {a[7:0] ^ a[23:16] ^ 8'h3C,
                a[15:0] ^ {a[23:16], a[23:16]} ^ 16'hA5C3};
    endfunction
    function automatic logic [15:0] ex(input logic hi, bm,
                                       input logic [15:0] ea);
        logic [23:0] w;
        w = pw({pg, ea[15:1], 1'b0});
        if (!bm)
            return hi ? {8'h00, w[23:16]} : w[15:0];
        if (hi)
            return ea[0] ? 16'h0000 : {8'h00, w[23:16]};
        return {8'h00, ea[0] ? w[15:8] : w[7:0]};
    endfunction
    task automatic report_and_stop;
        $display("Comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ***************************************************************
    // Sequence
    // ***************************************************************
    initial begin
        #400_000;
        num_errors++;
        $display("[FAIL] watchdog exp done got hang");
        report_and_stop();
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, PSTA_CTRL_OFF, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        chk("latch reset", 32'h00FF_FFFF, {8'h00, latch_lo_q});
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped data", 32'h0, rd);
        chk("unmapped error", 32'h1, {31'h0, err_seen});
        apb(1'b1, PSTA_ADRU_OFF, 32'h0000_007F);
        apb(1'b1, PSTA_ADRL_OFF, 32'h0000_1235);
        chk("flash addr", 32'h007F_1234, {8'h00, flash_addr});
        pc_word_index <= 23'h2A_AAAB;
        @(posedge pclk);
        chk("pc addr", 32'h0055_5556, {8'h00, pc_addr});
        $display("Registers and addressing done");
        pg = 8'h12;
        apb(1'b1, PSTA_PAGE_OFF, {24'h00_0000, pg});
        for (int k = 0; k < 7; k++) begin
            if (k == 6) begin
                pg = 8'h80;
                apb(1'b1, PSTA_PAGE_OFF, {24'h00_0000, pg});
            end
            tbl(k > 2 && k < 6 ? PSTA_RD_HIGH : PSTA_RD_LOW, bmv[k % 6],
                {15'h1A2B, eav[k % 6]}, 16'h0000);
            chk("table read", {16'h0000, ex(k > 2 && k < 6, bmv[k % 6],
                {15'h1A2B, eav[k % 6]}) & (bmv[k % 6] ? 16'h00FF : 16'hFFFF)},
                rd & (bmv[k % 6] ? 32'h00FF : 32'hFFFF));
        end
        win_page <= 8'hFF;
        win_ea <= 15'h1235;
        win_valid <= 1'b1;
        do @(posedge pclk); while (win_ack !== 1'b1 && tests_run < 10_000);
        win_valid <= 1'b0;
        @(posedge pclk);
        chk("window", {8'h00, pw(24'h7F_9234)} & 32'hFFFF,
            {16'h0000, win_rdata});
        tbl(PSTA_WR_LOW, 1'b0, 16'h0004, 16'hBEEF);
        chk("low latch", 32'h00FF_BEEF, {8'h00, latch_lo_q});
        tbl(PSTA_WR_HIGH, 1'b0, 16'h0006, 16'h0077);
        chk("high latch", 32'h0077_FFFF, {8'h00, latch_hi_q});
        $display("Table access done");
        for (int c = 0; c < 16; c++) begin
            start(32'h0000_C000 | c, 0);
            chk("erase busy", {31'h0, c == 3}, {31'h0, flash_erase_busy});
            chk("prog busy", {31'h0, c == 1}, {31'h0, flash_prog_busy});
            apb(1'b0, PSTA_CTRL_OFF, 32'h0);
            chk("trigger set", {31'h0, c == 1 || c == 3}, {31'h0, rd[15]});
            if (c == 3) begin
                tbl(PSTA_RD_LOW, 1'b0, 16'h3456, 16'h0000);
                chk("stalled read", {16'h0000, ex(1'b0, 1'b0, 16'h3456)}, rd);
            end
            wait_idle();
            apb(1'b0, PSTA_CTRL_OFF, 32'h0);
            chk("ctrl after op", (c == 1 || c == 3) ? c : 32'h2000 | c,
                rd & 32'hA00F);
            apb(1'b1, PSTA_CTRL_OFF, 32'h0);
        end
        $display("Operation codes done");
        for (int m = 0; m < 4; m++) begin
            start(m == 0 ? 32'h0000_8003 : m == 3 ? 32'h0000_D003
                  : 32'h0000_C003, m == 3 ? 0 : m);
            chk("no start", {31'h0, m == 3}, {31'h0, flash_erase_busy});
            if (m == 3) begin
                repeat (3) @(posedge pclk);
                idle_req <= 1'b1;
            end
            wait_idle();
            idle_req <= 1'b0;
            apb(1'b0, PSTA_CTRL_OFF, 32'h0);
            chk("sequence error", 32'h2000, rd & 32'hA000);
            apb(1'b1, PSTA_CTRL_OFF, 32'h0);
        end
        $display("Faulty sequences done");
        report_and_stop();
    end
endmodule // test_program_space_table_access
bind psta_top psta_top_props #(.ERASE_LEN(ERASE_LEN), .PROG_LEN(PROG_LEN))
    i_psta_top_props (.*);

// [verilog/psta_lane.sv]
// Purpose: Maps a 24-bit program word onto a 16-bit data result
// Assumes: Purely combinational
// Notes:   Phantom upper byte always reads as zero
`timescale 1ns/1ps
module psta_lane (
    input  wire logic [23:0]       pword,
    input  wire psta_pkg::psta_op_t op,
    input  wire logic              byte_mode,
    input  wire logic              byte_sel,
    output logic      [15:0]       rdata
);
    import psta_pkg::*;

    always_comb begin
        rdata = 16'h0000;
        if (op == PSTA_RD_LOW) begin
            if (!byte_mode) begin
                rdata = pword[15:0];
            end else if (byte_sel) begin
                rdata = {8'h00, pword[15:8]};
            end else begin
                rdata = {8'h00, pword[7:0]};
            end
        end else if (op == PSTA_RD_HIGH) begin
            if (!byte_mode || !byte_sel) begin
                rdata = {8'h00, pword[23:16]};
            end else begin
                rdata = 16'h0000;
            end
        end
    end

endmodule // psta_lane

// [verilog/psta_pkg.sv]
// Purpose: Constants and types for program space table access block
// Assumes: 50 MHz pclk, APB register port, 16-bit data words
// Notes:   Register offsets are byte addresses of aligned 32-bit words
//
// Summary of operation
// - Program words 24 bits, data words 16 bits
// - Program address bit zero always forced low
// - Address is page byte above data EA
// - Page top bit selects user or configuration
// - Low word read returns program bits 15:0
// - Low byte read picks byte by select bit
// - High word read: bits 23:16, upper zero
// - High byte read: phantom byte reads zero
// - Byte addresses accepted; configuration reads allowed
// - Program counter steps by two per word
// - Low ops bits 15:0, high ops 23:16
// - Visibility window reads low word only
// - Erase clears a 1024-location page
// - Program operation writes two words
// - Processor stalled while flash busy
// - Trigger bit 15 starts, clears at end
// - Unlock with 0x55 then 0xAA first
// - Op 0011 erase, 0001 double-word program
// - No operation unless write enable set
// - Sticky error on improper start or abort
package psta_pkg;

    // ***************************************************************
    // Register map
    // ***************************************************************
    localparam logic [7:0] PSTA_CTRL_OFF  = 8'h00;
    localparam logic [7:0] PSTA_KEY_OFF   = 8'h04;
    localparam logic [7:0] PSTA_ADRU_OFF  = 8'h08;
    localparam logic [7:0] PSTA_ADRL_OFF  = 8'h0C;
    localparam logic [7:0] PSTA_PAGE_OFF  = 8'h10;

    // ***************************************************************
    // Control fields
    // ***************************************************************
    localparam int TRIG_BIT  = 15;
    localparam int WENA_BIT  = 14;
    localparam int ERR_BIT   = 13;
    localparam int SIDL_BIT  = 12;
    localparam int OPSEL_MSB = 3;
    localparam logic [3:0] OP_ERASE = 4'h3;
    localparam logic [3:0] OP_PROG2 = 4'h1;
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    // ***************************************************************
    // Geometry and timing
    // ***************************************************************
    localparam int PAGE_WORDS   = 1024;
    localparam int PROG_WORDS   = 2;
    localparam int PC_STEP      = 2;
    localparam int CLK_MHZ      = 50;
    localparam int ERASE_US     = 20000;
    localparam int PROG_US      = 50;
    localparam int ERASE_CYCLES = ERASE_US * CLK_MHZ;
    localparam int PROG_CYCLES  = PROG_US * CLK_MHZ;
    localparam int CFG_BIT      = 7;

    typedef enum logic [1:0] {
        PSTA_RD_LOW,
        PSTA_RD_HIGH,
        PSTA_WR_LOW,
        PSTA_WR_HIGH
    } psta_op_t;

    // Table access request from the core
    typedef struct packed {
        logic        valid;
        psta_op_t    op;
        logic        byte_mode;
        logic [15:0] ea;
        logic [15:0] wdata;
    } psta_req_t;

    // Flash array command
    typedef struct packed {
        logic        write_low;
        logic        write_high;
        logic        read;
        logic [23:0] addr;
        logic [23:0] wdata;
    } psta_mem_t;

endpackage

// [verilog/psta_top.sv]
// Purpose: Table access, visibility window and flash operation control
// Assumes: Core holds a table request until ack; flash array is external
// Notes:   Operation lengths are parameters so simulation may shorten
`timescale 1ns/1ps
module psta_top #(
    parameter int ERASE_LEN = psta_pkg::ERASE_CYCLES,
    parameter int PROG_LEN  = psta_pkg::PROG_CYCLES
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire psta_pkg::psta_req_t tbl_req,
    output logic                     tbl_ack,
    output logic      [15:0]         tbl_rdata,
    input  wire logic                win_valid,
    input  wire logic [7:0]          win_page,
    input  wire logic [14:0]         win_ea,
    output logic                     win_ack,
    output logic      [15:0]         win_rdata,
    input  wire logic [22:0]         pc_word_index,
    output logic      [23:0]         pc_addr,
    output psta_pkg::psta_mem_t      mem_cmd,
    input  wire logic [23:0]         mem_rdata,
    output logic                     flash_erase_busy,
    output logic                     flash_prog_busy,
    output logic      [23:0]         flash_addr,
    output logic      [23:0]         latch_lo_q,
    output logic      [23:0]         latch_hi_q,
    output logic                     cpu_stall,
    input  wire logic                idle_req
);
    import psta_pkg::*;

    if (ERASE_LEN < 1 || PROG_LEN < 1) begin : g_len_check
        $error("Operation lengths must be at least one cycle");
    end

    // ***************************************************************
    // Address forming
    // ***************************************************************
    function automatic logic [23:0] tbl_addr(input logic [7:0]  page,
                                             input logic [15:0] ea);
        tbl_addr = {page, ea[15:1], 1'b0};
    endfunction

    typedef enum {
        F_IDLE,
        F_ERASE,
        F_PROG
    } psta_fstate_t;

    logic [7:0]   page_q,   page_d;
    logic [7:0]   adru_q,   adru_d;
    logic [15:0]  adrl_q,   adrl_d;
    logic         trig_q,   trig_d;
    logic         wena_q,   wena_d;
    logic         err_q,    err_d;
    logic         sidl_q,   sidl_d;
    logic [3:0]   opsel_q,  opsel_d;
    logic         key1_q,   key1_d;
    logic         unlock_q, unlock_d;
    logic [23:0]  lo_q,     lo_d;
    logic [23:0]  hi_q,     hi_d;
    logic [31:0]  cnt_q,    cnt_d;
    psta_fstate_t st_q,     st_d;
    logic [31:0]  rd_d;
    logic [31:0]  rd_q;
    logic [23:0]  taddr;
    logic [15:0]  lane_data;
    logic         apb_wr;
    logic         apb_rd;
    logic         hit;
    logic         is_write;

    assign apb_wr   = psel && penable && pwrite;
    assign apb_rd   = psel && !penable && !pwrite;
    assign pready   = 1'b1;
    assign hit      = paddr == PSTA_CTRL_OFF || paddr == PSTA_KEY_OFF ||
                      paddr == PSTA_ADRU_OFF || paddr == PSTA_ADRL_OFF ||
                      paddr == PSTA_PAGE_OFF;
    assign pslverr  = psel && penable && !hit;
    assign prdata   = rd_q;

    // ***************************************************************
    // Table access path
    // ***************************************************************
    assign taddr    = tbl_addr(page_q, tbl_req.ea);
    assign is_write = tbl_req.op == PSTA_WR_LOW ||
                      tbl_req.op == PSTA_WR_HIGH;
    // Stall table and window traffic while the array is busy
    assign cpu_stall = st_q != F_IDLE;
    assign tbl_ack   = tbl_req.valid && !cpu_stall;
    assign win_ack   = win_valid && !cpu_stall && !tbl_req.valid;
    // Word index doubled so program words line up with data words
    assign pc_addr   = {pc_word_index, 1'b0};

    always_comb begin
        mem_cmd = '0;
        if (tbl_ack && !is_write) begin
            mem_cmd.read = 1'b1;
            mem_cmd.addr = taddr;
        end else if (win_ack) begin
            mem_cmd.read = 1'b1;
            // Window always in user space, upper byte never returned
            mem_cmd.addr = tbl_addr({1'b0, win_page[6:0]},
                                    {1'b1, win_ea});
        end
    end

    psta_lane i_psta_lane (
        .pword     (mem_rdata),
        .op        (tbl_req.op),
        .byte_mode (tbl_req.byte_mode),
        .byte_sel  (tbl_req.ea[0]),
        .rdata     (lane_data)
    );

    logic [15:0] tbl_rdata_q;
    logic [15:0] win_rdata_q;
    assign tbl_rdata = tbl_rdata_q;
    assign win_rdata = win_rdata_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tbl_rdata_q <= 16'h0000;
            win_rdata_q <= 16'h0000;
        end else begin
            if (tbl_ack && !is_write) begin
                tbl_rdata_q <= lane_data;
            end
            if (win_ack) begin
                win_rdata_q <= mem_rdata[15:0];
            end
        end
    end

    // ***************************************************************
    // Registers, unlock and flash sequencer
    // ***************************************************************
    always_comb begin
        page_d   = page_q;
        adru_d   = adru_q;
        adrl_d   = adrl_q;
        trig_d   = trig_q;
        wena_d   = wena_q;
        err_d    = err_q;
        sidl_d   = sidl_q;
        opsel_d  = opsel_q;
        key1_d   = key1_q;
        unlock_d = unlock_q;
        lo_d     = lo_q;
        hi_d     = hi_q;
        cnt_d    = cnt_q;
        st_d     = st_q;
        rd_d     = rd_q;
        // Write latches load from table writes, byte or word wide
        if (tbl_ack && is_write) begin
            if (tbl_req.ea[1]) begin
                if (tbl_req.op == PSTA_WR_LOW) begin
                    if (!tbl_req.byte_mode) begin
                        hi_d[15:0] = tbl_req.wdata;
                    end else if (tbl_req.ea[0]) begin
                        hi_d[15:8] = tbl_req.wdata[7:0];
                    end else begin
                        hi_d[7:0] = tbl_req.wdata[7:0];
                    end
                end else if (!tbl_req.byte_mode || !tbl_req.ea[0]) begin
                    hi_d[23:16] = tbl_req.wdata[7:0];
                end
            end else begin
                if (tbl_req.op == PSTA_WR_LOW) begin
                    if (!tbl_req.byte_mode) begin
                        lo_d[15:0] = tbl_req.wdata;
                    end else if (tbl_req.ea[0]) begin
                        lo_d[15:8] = tbl_req.wdata[7:0];
                    end else begin
                        lo_d[7:0] = tbl_req.wdata[7:0];
                    end
                end else if (!tbl_req.byte_mode || !tbl_req.ea[0]) begin
                    lo_d[23:16] = tbl_req.wdata[7:0];
                end
            end
        end
        // Key: any key write other than the expected next byte re-locks
        if (apb_wr && paddr == PSTA_KEY_OFF) begin
            key1_d   = pwdata[7:0] == KEY_FIRST;
            unlock_d = key1_q && pwdata[7:0] == KEY_SECOND;
        end else if (apb_wr) begin
            key1_d   = 1'b0;
            unlock_d = 1'b0;
        end
        if (apb_wr && paddr == PSTA_CTRL_OFF) begin
            sidl_d = pwdata[SIDL_BIT];
            if (st_q == F_IDLE) begin
                wena_d  = pwdata[WENA_BIT];
                opsel_d = pwdata[OPSEL_MSB:0];
                if (!pwdata[ERR_BIT]) begin
                    err_d = 1'b0;
                end
                if (pwdata[TRIG_BIT]) begin
                    unlock_d = 1'b0;
                    key1_d   = 1'b0;
                    if (!unlock_q || !pwdata[WENA_BIT]) begin
                        err_d = 1'b1;
                    end else if (pwdata[OPSEL_MSB:0] == OP_ERASE) begin
                        trig_d = 1'b1;
                        st_d   = F_ERASE;
                        cnt_d  = 32'(ERASE_LEN - 1);
                    end else if (pwdata[OPSEL_MSB:0] == OP_PROG2) begin
                        trig_d = 1'b1;
                        st_d   = F_PROG;
                        cnt_d  = 32'(PROG_LEN - 1);
                    end else begin
                        err_d = 1'b1;
                    end
                end
            end
        end
        if (apb_wr && paddr == PSTA_ADRU_OFF && st_q == F_IDLE) begin
            adru_d = pwdata[7:0];
        end
        if (apb_wr && paddr == PSTA_ADRL_OFF && st_q == F_IDLE) begin
            adrl_d = pwdata[15:0];
        end
        if (apb_wr && paddr == PSTA_PAGE_OFF) begin
            page_d = pwdata[7:0];
        end
        case (st_q)
            F_IDLE: begin
            end
            F_ERASE, F_PROG: begin
                if (idle_req && sidl_q) begin
                    st_d   = F_IDLE;
                    trig_d = 1'b0;
                    err_d  = 1'b1;
                end else if (cnt_q == '0) begin
                    st_d   = F_IDLE;
                    trig_d = 1'b0;
                end else begin
                    cnt_d = cnt_q - 32'd1;
                end
            end
            default: begin
                st_d = F_IDLE;
            end
        endcase
        if (apb_rd) begin
            case (paddr)
                PSTA_CTRL_OFF: begin
                    rd_d = 32'h0000_0000;
                    rd_d[TRIG_BIT]      = trig_q;
                    rd_d[WENA_BIT]      = wena_q;
                    rd_d[ERR_BIT]       = err_q;
                    rd_d[SIDL_BIT]      = sidl_q;
                    rd_d[OPSEL_MSB:0]   = opsel_q;
                end
                PSTA_ADRU_OFF: rd_d = {24'h00_0000, adru_q};
                PSTA_ADRL_OFF: rd_d = {16'h0000, adrl_q};
                PSTA_PAGE_OFF: rd_d = {24'h00_0000, page_q};
                default: rd_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_q   <= 8'h00;
            adru_q   <= 8'h00;
            adrl_q   <= 16'h0000;
            trig_q   <= 1'b0;
            wena_q   <= 1'b0;
            err_q    <= 1'b0;
            sidl_q   <= 1'b0;
            opsel_q  <= 4'h0;
            key1_q   <= 1'b0;
            unlock_q <= 1'b0;
            lo_q     <= 24'hFF_FFFF;
            hi_q     <= 24'hFF_FFFF;
            cnt_q    <= 32'h0000_0000;
            st_q     <= F_IDLE;
            rd_q     <= 32'h0000_0000;
        end else begin
            page_q   <= page_d;
            adru_q   <= adru_d;
            adrl_q   <= adrl_d;
            trig_q   <= trig_d;
            wena_q   <= wena_d;
            err_q    <= err_d;
            sidl_q   <= sidl_d;
            opsel_q  <= opsel_d;
            key1_q   <= key1_d;
            unlock_q <= unlock_d;
            lo_q     <= lo_d;
            hi_q     <= hi_d;
            cnt_q    <= cnt_d;
            st_q     <= st_d;
            rd_q     <= rd_d;
        end
    end

    // ***************************************************************
    // Flash array control outputs
    // ***************************************************************
    // Erase covers the page holding the address; program writes a pair
    assign flash_erase_busy = st_q == F_ERASE;
    assign flash_prog_busy  = st_q == F_PROG;
    assign flash_addr       = {adru_q, adrl_q[15:1], 1'b0};
    assign latch_lo_q       = lo_q;
    assign latch_hi_q       = hi_q;

endmodule // psta_top
